// file: core/bank_mem.sv
// banked data memory: address generation, storage and bank select register
// assumes the core presents one request per instruction cycle, held during phase one,
// with write data valid at phase four; registers reached over classic wishbone
// How it works
// - data addresses are 12 bits wide, covering 4096 bytes.
// - the space is sixteen banks of 256 bytes each.
// - unimplemented locations read as zero; unused register slots in f53h-fffh read back their stored value.
// - banked address is bank select as upper nibble, operand offset as low byte.
// - bank select keeps only bits 3..0; upper bits read zero, ignore writes.
// - a load-bank instruction loads bank select straight from its literal.
// - unimplemented banks drop writes and read back zero.
// - the access still completes normally so the flags update as if successful.
// - full-address move uses its own 12-bit source and destination, never bank select.
// - all other instructions resolve through bank select or the access bank.
// - access offsets 00-5f hit bank 0, offsets 60-ff hit top of bank 15.
// - access bit one uses bank select; zero uses the access map.
// - an access-bank operand completes in one instruction cycle, no bank update.
// - this map applies only while the extended instruction bit is clear.
// - general purpose RAM is never cleared by any reset.
// - general purpose RAM starts at 000h in bank 0 and grows upward.
// - function registers fill f53h to fffh as static storage.
// - registers f53h-f5fh are reachable only banked or by full address.
// - operand read happens in phase two, destination write in phase four.
//
// The Wishbone interface to the registers and the register addresses were left to the implementer.
module bank_mem
  import bank_mem_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // core request side
  input wire req_t req_i,
  input wire logic [7:0] wdata_i,
  output logic [1:0] phase_o,
  output logic [7:0] rdata_o,
  output logic [11:0] eff_addr_o,
  output logic access_done_o,
  output logic unsupported_o,
  output logic [3:0] bank_select_o,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  phase_t phase_q;
  req_t cur_q;
  logic [3:0] bank_select_q;
  logic ext_q;
  logic [7:0] rdata_q;
  logic [11:0] eff_addr_q;
  logic done_q;
  logic unsup_q;
  logic impl_q;
  logic ack_q;
  logic [31:0] wb_dat_q;

  // storage is left without reset so power-up contents stay undefined
  logic [7:0] gpr_mem [0:GPR_BYTES-1];
  logic [7:0] sfr_mem [0:SFR_BYTES-1];

  // address generation
  wire is_full = cur_q.op == OP_FULL_MOVE;
  wire is_banked = cur_q.op == OP_BANKED;
  wire is_load = cur_q.op == OP_LOAD_BANK;
  wire [11:0] banked_addr = {bank_select_q, cur_q.offset};
  wire access_low = cur_q.offset < ACCESS_SPLIT;
  wire [3:0] access_bank = access_low ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK;
  wire [11:0] access_addr = {access_bank, cur_q.offset};
  wire [11:0] short_addr = cur_q.access_bit ? banked_addr : access_addr;
  wire [11:0] rd_addr = is_full ? cur_q.src : short_addr;
  wire [11:0] wr_addr = is_full ? cur_q.dst : short_addr;
  // the extended map is not built here; such accesses are treated as void
  wire unsup = ext_q && is_banked && !cur_q.access_bit;

  // decode of the read target
  wire rd_gpr = rd_addr <= GPR_TOP;
  wire rd_sfr = rd_addr >= SFR_LOW;
  wire rd_bsel = rd_addr == BANK_SEL_ADDR;
  wire [7:0] rd_sidx = rd_addr[7:0] - SFR_IDX_BASE;
  wire [7:0] rd_gval = gpr_mem[rd_addr[8:0]];
  wire [7:0] rd_sval = sfr_mem[rd_sidx];
  wire [7:0] rd_bval = {4'h0, bank_select_q};
  wire [7:0] rd_mux = rd_bsel ? rd_bval : rd_sfr ? rd_sval : rd_gpr ? rd_gval : 8'h00;
  wire rd_impl = rd_bsel || rd_sfr || rd_gpr;
  wire [7:0] rd_val = unsup ? 8'h00 : rd_mux;

  // decode of the write target
  wire wr_gpr = wr_addr <= GPR_TOP;
  wire wr_sfr = wr_addr >= SFR_LOW;
  wire wr_bsel = wr_addr == BANK_SEL_ADDR;
  wire [7:0] wr_sidx = wr_addr[7:0] - SFR_IDX_BASE;
  wire [7:0] wr_val = is_full ? rdata_q : wdata_i;
  wire in_ph4 = phase_q == PH_FOUR;
  wire wr_go = in_ph4 && cur_q.valid && !unsup && (is_full || (is_banked && cur_q.wr));
  // writes outside implemented areas simply fall through
  wire wr_gpr_en = wr_go && wr_gpr && !wr_bsel;
  wire wr_sfr_en = wr_go && wr_sfr && !wr_bsel;
  wire core_bsel_wr = wr_go && wr_bsel;
  wire load_go = in_ph4 && cur_q.valid && is_load;

  // wishbone decode
  wire wb_req = wb_cyc_i && wb_stb_i && !ack_q;
  wire wb_wr = wb_cyc_i && wb_stb_i && ack_q && wb_we_i && wb_sel_i[0];
  wire hit_bsel = wb_adr_i == REG_BANK_SELECT;
  wire hit_ctrl = wb_adr_i == REG_CONTROL;
  wire hit_stat = wb_adr_i == REG_STATUS;
  wire [31:0] bsel_word = {28'h0, bank_select_q};
  wire [31:0] ctrl_word = {31'h0, ext_q};
  wire [31:0] stat_word = {14'h0, impl_q, unsup_q, 4'h0, eff_addr_q};
  wire [31:0] stat_or_0 = hit_stat ? stat_word : 32'h0;
  wire [31:0] ctrl_or = hit_ctrl ? ctrl_word : stat_or_0;
  wire [31:0] wb_rd_mux = hit_bsel ? bsel_word : ctrl_or;
  wire wb_bsel_wr = wb_wr && hit_bsel;
  wire wb_ctrl_wr = wb_wr && hit_ctrl;

  // a core write to bank select wins over a bus write in the same cycle; that bus write is dropped
  wire [3:0] bsel_from_core = load_go ? cur_q.literal[3:0] : wr_val[3:0];
  wire core_bsel_any = load_go || core_bsel_wr;
  wire [3:0] bsel_d = core_bsel_any ? bsel_from_core : wb_dat_i[3:0];
  wire bsel_we = core_bsel_any || wb_bsel_wr;

  // four quarter phases per instruction cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_q <= PH_ONE;
    end else begin
      phase_q <= phase_t'(phase_q + 2'h1);
    end
  end

  // instruction latch at phase one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur_q <= '0;
    end else if (phase_q == PH_ONE) begin
      cur_q <= req_i;
    end
  end

  // operand read at phase two
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q <= 8'h00;
      eff_addr_q <= 12'h000;
      unsup_q <= 1'b0;
      impl_q <= 1'b0;
    end else if (phase_q == PH_TWO && cur_q.valid) begin
      rdata_q <= rd_val;
      eff_addr_q <= rd_addr;
      unsup_q <= unsup;
      impl_q <= rd_impl && !unsup;
    end
  end

  // completion pulse regardless of target, so status flags update as usual
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_q <= 1'b0;
    end else begin
      done_q <= in_ph4 && cur_q.valid;
    end
  end

  // bank select and control
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bank_select_q <= BANK_SEL_RESET;
      ext_q <= EXT_RESET;
    end else begin
      if (bsel_we) begin
        bank_select_q <= bsel_d;
      end
      if (wb_ctrl_wr) begin
        ext_q <= wb_dat_i[CTRL_EXT_BIT];
      end
    end
  end

  // storage arrays, no reset
  always_ff @(posedge clk_i) begin
    if (wr_gpr_en) begin
      gpr_mem[wr_addr[8:0]] <= wr_val;
    end
    if (wr_sfr_en) begin
      sfr_mem[wr_sidx] <= wr_val;
    end
  end

  // bus answer one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      wb_dat_q <= 32'h0;
    end else begin
      ack_q <= wb_req;
      wb_dat_q <= wb_req ? wb_rd_mux : 32'h0;
    end
  end

  assign phase_o = phase_q;
  assign rdata_o = rdata_q;
  assign eff_addr_o = eff_addr_q;
  assign access_done_o = done_q;
  assign unsupported_o = unsup_q;
  assign bank_select_o = bank_select_q;
  assign wb_dat_o = wb_dat_q;
  assign wb_ack_o = ack_q;

  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence ph_walk_s;
    phase_q == PH_ONE ##1 phase_q == PH_TWO ##1 phase_q == PH_THREE ##1 phase_q == PH_FOUR;
  endsequence

  sequence ph2_req_s;
    phase_q == PH_TWO && cur_q.valid;
  endsequence

  phase_order_a: assert property (phase_q == PH_ONE |-> ph_walk_s ##1 phase_q == PH_ONE)
    else $error("quarter phases out of order");

  bsel_upper_a: assert property (ack_q && $past(hit_bsel) |-> wb_dat_o[31:4] == 28'h0)
    else $error("bank select upper bits not zero");

  unimpl_read_a: assert property (ph2_req_s and !rd_impl |=> rdata_o == 8'h00)
    else $error("unimplemented location read nonzero");

  access_low_a: assert property (ph2_req_s and (is_banked && !cur_q.access_bit && access_low)
    |=> eff_addr_o[11:8] == 4'h0 && eff_addr_o[7:0] < 8'h60)
    else $error("low access offset not in bank 0");

  access_high_a: assert property (ph2_req_s and (is_banked && !cur_q.access_bit && !access_low)
    |=> eff_addr_o[11:8] == 4'hf)
    else $error("high access offset not in bank 15");

  banked_addr_a: assert property (ph2_req_s and (is_banked && cur_q.access_bit)
    |=> eff_addr_o == {$past(bank_select_q), $past(cur_q.offset)})
    else $error("banked address mismatch");

  full_move_a: assert property (ph2_req_s and is_full |=> eff_addr_o == $past(cur_q.src))
    else $error("full move source ignored");

  load_bank_a: assert property (load_go |=> bank_select_q == $past(cur_q.literal[3:0]))
    else $error("bank select not loaded from literal");

  done_cycle_a: assert property (phase_q == PH_ONE ##1 ph2_req_s
    |-> ##3 access_done_o)
    else $error("access did not complete in its cycle");

  ext_void_a: assert property (ph2_req_s and unsup |=> rdata_o == 8'h00 && unsupported_o)
    else $error("extended mode access not voided");

  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held more than one cycle");

  // a full move reads in phase two and writes two phases later
  sequence full_move_s;
    ph2_req_s and is_full;
  endsequence

  sequence ph4_wr_s;
    in_ph4 && cur_q.valid;
  endsequence

  // address path
  eff_hold_a: assert property (phase_q != PH_TWO |=> $stable(eff_addr_o))
    else $error("effective address moved outside phase two");

  rdata_hold_a: assert property (phase_q != PH_TWO |=> $stable(rdata_o))
    else $error("operand changed outside phase two");

  unsup_hold_a: assert property (phase_q != PH_TWO |=> $stable(unsupported_o))
    else $error("unsupported flag changed outside phase two");

  req_latch_a: assert property (phase_q == PH_ONE |=> cur_q == $past(req_i))
    else $error("request not latched at end of phase one");

  latch_hold_a: assert property (phase_q != PH_ONE |=> $stable(cur_q))
    else $error("latched request changed mid cycle");

  access_gap_a: assert property (ph2_req_s and (is_banked && !cur_q.access_bit)
    |=> !(eff_addr_o >= SFR_LOW && eff_addr_o < SFR_ACCESS_LOW))
    else $error("access map reached the hidden registers");

  access_offs_a: assert property (ph2_req_s and (is_banked && !cur_q.access_bit)
    |=> eff_addr_o[7:0] == $past(cur_q.offset))
    else $error("access map changed the offset");

  bank_field_a: assert property (ph2_req_s and (is_banked && cur_q.access_bit)
    |=> eff_addr_o[11:8] == $past(bank_select_q))
    else $error("bank field not taken from bank select");

  full_dst_a: assert property (full_move_s |-> ##2 wr_go && wr_addr == cur_q.dst)
    else $error("full move destination not written");

  // read values
  unimpl_bank_a: assert property (ph2_req_s and (rd_addr[11:9] != 3'h0 && rd_addr < SFR_LOW)
    |=> rdata_o == 8'h00)
    else $error("unimplemented bank read nonzero");

  bsel_read_a: assert property (ph2_req_s and rd_bsel |=> rdata_o[7:4] == 4'h0)
    else $error("bank select upper nibble read nonzero");

  impl_void_a: assert property (ph2_req_s and unsup |=> !impl_q)
    else $error("void access flagged as implemented");

  ext_off_a: assert property (ph2_req_s and !ext_q |=> !unsupported_o)
    else $error("unsupported flag without extended mode");

  // writes and bank select
  gpr_write_a: assert property (wr_gpr_en
    |=> gpr_mem[$past(wr_addr[8:0])] == $past(wr_val))
    else $error("general purpose write lost");

  sfr_write_a: assert property (wr_sfr_en
    |=> sfr_mem[$past(wr_sidx)] == $past(wr_val))
    else $error("function register write lost");

  write_phase_a: assert property (wr_go |-> phase_q == PH_FOUR)
    else $error("memory write outside phase four");

  core_bsel_a: assert property (core_bsel_wr
    |=> bank_select_q == $past(wr_val[3:0]))
    else $error("core write to bank select lost");

  bus_bsel_a: assert property (wb_bsel_wr && !core_bsel_any
    |=> bank_select_q == $past(wb_dat_i[3:0]))
    else $error("bus write to bank select lost");

  bsel_quiet_a: assert property (!bsel_we |=> $stable(bank_select_q))
    else $error("bank select changed without a write");

  ext_quiet_a: assert property (!wb_ctrl_wr |=> $stable(ext_q))
    else $error("extended bit changed without a write");

  ctrl_wr_a: assert property (wb_ctrl_wr |=> ext_q == $past(wb_dat_i[0]))
    else $error("extended bit write lost");

  // completion and bus
  done_ph1_a: assert property (access_done_o |-> phase_q == PH_ONE)
    else $error("completion outside phase one");

  done_pulse_a: assert property (access_done_o |=> !access_done_o)
    else $error("completion held more than one cycle");

  done_idle_a: assert property (in_ph4 && !cur_q.valid |=> !access_done_o)
    else $error("completion without a request");

  ph4_done_a: assert property (ph4_wr_s |=> access_done_o)
    else $error("valid request did not complete");

  ack_req_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");

  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("bus data not zero while idle");

  unmapped_a: assert property (wb_ack_o && !$past(hit_bsel || hit_ctrl || hit_stat)
    |-> wb_dat_o == 32'h0)
    else $error("unmapped bus read nonzero");

endmodule // bank_mem

// file: core/bank_mem_pkg.sv
// constants, request carrier and opcodes for the banked data memory block
// assumes a single 125 MHz clock shared with the core decode logic
package bank_mem_pkg;
  // address space and banking
  localparam int ADDR_W = 12;
  localparam int BANK_W = 4;
  localparam int OFFS_W = 8;
  localparam int BANK_COUNT = 16;
  localparam int BANK_BYTES = 256;
  // implemented storage
  localparam logic [11:0] GPR_BASE = 12'h000;
  localparam logic [11:0] GPR_TOP = 12'h1ff;
  localparam int GPR_BYTES = 512;
  localparam logic [11:0] SFR_LOW = 12'hf53;
  localparam logic [11:0] SFR_ACCESS_LOW = 12'hf60;
  localparam logic [11:0] SFR_TOP = 12'hfff;
  localparam int SFR_BYTES = 173;
  localparam logic [7:0] SFR_IDX_BASE = 8'h53;
  localparam logic [11:0] BANK_SEL_ADDR = 12'hfe0;
  // access bank split
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
  // reset values
  localparam logic [3:0] BANK_SEL_RESET = 4'h0;
  localparam logic EXT_RESET = 1'b0;
  // register bus offsets (byte addresses)
  localparam int WB_ADR_W = 8;
  localparam logic [7:0] REG_BANK_SELECT = 8'h00;
  localparam logic [7:0] REG_CONTROL = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  // field positions
  localparam int CTRL_EXT_BIT = 0;
  localparam int STAT_UNSUP_BIT = 16;
  localparam int STAT_IMPL_BIT = 17;
  // instruction cycle quarter phases
  typedef enum logic [1:0] {
    PH_ONE,
    PH_TWO,
    PH_THREE,
    PH_FOUR
  } phase_t;
  typedef enum logic [1:0] {
    OP_BANKED,
    OP_FULL_MOVE,
    OP_LOAD_BANK
  } op_t;
  typedef struct packed {
    logic valid;
    op_t op;
    logic access_bit;
    logic wr;
    logic [7:0] offset;
    logic [11:0] src;
    logic [11:0] dst;
    logic [7:0] literal;
  } req_t;
endpackage

// file: verification/core_model.sv
// behavioural stand-in for the core decode/execute logic driving the request side
// assumes phase_i is the memory block's free-running quarter-phase output
module core_model
  import bank_mem_pkg::*;
(
  // clock and phase
  input wire logic clk_i,
  input wire logic [1:0] phase_i,
  // request side
  output req_t req_o,
  output logic [7:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    req_o = '0;
    wdata_o = 8'h00;
  end
  // one request per instruction cycle, presented for phase one and held to the end
  task automatic issue(input req_t r, input logic [7:0] wd);
    req_t idle;
    idle = ~r;
    idle.valid = 1'b0;
    do @(posedge clk_i); while (phase_i !== 2'd3);
    req_o <= r;
    wdata_o <= wd;
    repeat (4) @(posedge clk_i);
    // released lines show the inverse so a stale value can never pass
    req_o <= idle;
    wdata_o <= ~wd;
  endtask
endmodule // core_model

// file: verification/tb_top.sv
// self-checking bench for the banked data memory block
// assumes one 125 MHz clock, the core model file and wishbone register access
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import bank_mem_pkg::*;
  typedef struct {
    op_t op; logic a; logic wr; logic [7:0] off; logic [11:0] src; logic [11:0] dst;
    logic [7:0] wd; logic [7:0] rd; logic [11:0] ea; logic [3:0] bs; logic [1:0] chk;
  } row_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat = 32'h0, wb_dat_o, q;
  logic wb_ack_o, access_done_o, unsupported_o;
  logic [1:0] phase_o;
  logic [7:0] rdata_o, wdata;
  logic [11:0] eff_addr_o;
  logic [3:0] bank_select_o;
  req_t req;
  int n_fail = 0, compares = 0;
  // op, a, wr, offset or literal, src, dst, wdata, rdata, eff addr, bank select, {ea,rd} check
  row_t rows[16] = '{
    '{OP_LOAD_BANK, 0, 0, 8'hf1, 12'h0, 12'h0, 8'h00, 8'h00, 12'h000, 4'h1, 2'd0},
    '{OP_BANKED, 1, 1, 8'h10, 12'h0, 12'h0, 8'h5a, 8'h00, 12'h110, 4'h1, 2'd2},
    '{OP_BANKED, 1, 0, 8'h10, 12'h0, 12'h0, 8'h00, 8'h5a, 12'h110, 4'h1, 2'd3},
    '{OP_BANKED, 0, 1, 8'h10, 12'h0, 12'h0, 8'ha5, 8'h00, 12'h010, 4'h1, 2'd2},
    '{OP_BANKED, 1, 0, 8'h10, 12'h0, 12'h0, 8'h00, 8'h5a, 12'h110, 4'h1, 2'd3},
    '{OP_FULL_MOVE, 0, 0, 8'h00, 12'h010, 12'h1ff, 8'h00, 8'ha5, 12'h010, 4'h1, 2'd3},
    '{OP_BANKED, 0, 1, 8'h60, 12'h0, 12'h0, 8'h3c, 8'h00, 12'hf60, 4'h1, 2'd2},
    '{OP_LOAD_BANK, 0, 0, 8'h0f, 12'h0, 12'h0, 8'h00, 8'h00, 12'h000, 4'hf, 2'd0},
    '{OP_BANKED, 1, 0, 8'h60, 12'h0, 12'h0, 8'h00, 8'h3c, 12'hf60, 4'hf, 2'd3},
    '{OP_BANKED, 1, 1, 8'h55, 12'h0, 12'h0, 8'h77, 8'h00, 12'hf55, 4'hf, 2'd2},
    '{OP_BANKED, 0, 0, 8'h55, 12'h0, 12'h0, 8'h00, 8'h00, 12'h055, 4'hf, 2'd2},
    '{OP_FULL_MOVE, 0, 0, 8'h00, 12'hf55, 12'h030, 8'h00, 8'h77, 12'hf55, 4'hf, 2'd3},
    '{OP_LOAD_BANK, 0, 0, 8'h05, 12'h0, 12'h0, 8'h00, 8'h00, 12'h000, 4'h5, 2'd0},
    '{OP_BANKED, 1, 1, 8'h20, 12'h0, 12'h0, 8'h99, 8'h00, 12'h520, 4'h5, 2'd2},
    '{OP_BANKED, 1, 0, 8'h20, 12'h0, 12'h0, 8'h00, 8'h00, 12'h520, 4'h5, 2'd3},
    '{OP_FULL_MOVE, 0, 0, 8'h00, 12'h1ff, 12'h000, 8'h00, 8'ha5, 12'h1ff, 4'h5, 2'd3}};

  initial begin
    forever #4 clk_i = ~clk_i;
  end

  bank_mem u_dut (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .wdata_i(wdata),
    .phase_o(phase_o), .rdata_o(rdata_o), .eff_addr_o(eff_addr_o),
    .access_done_o(access_done_o), .unsupported_o(unsupported_o),
    .bank_select_o(bank_select_o), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o));
  core_model u_core (.clk_i(clk_i), .phase_i(phase_o), .req_o(req), .wdata_o(wdata));

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat <= d;
    wb_sel <= 4'hf;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  // issues one row and checks the outcome once the access has completed
  task automatic run(input row_t r);
    req_t x;
    x = '0;
    x.valid = 1'b1;
    x.op = r.op;
    x.access_bit = r.a;
    x.wr = r.wr;
    x.offset = r.off;
    x.literal = r.off;
    x.src = r.src;
    x.dst = r.dst;
    u_core.issue(x, r.wd);
    #1;
    `CHK("done", 1'b1, access_done_o)
    `CHK("bank", r.bs, bank_select_o)
    if (r.chk[1]) `CHK("addr", r.ea, eff_addr_o)
    if (r.chk[0]) `CHK("rdata", r.rd, rdata_o)
  endtask

  task automatic do_reset();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    `CHK("rst_phase", 2'd0, phase_o)
    `CHK("rst_bank", 4'h0, bank_select_o)
    @(posedge clk_i);
    rst_i <= 1'b0;
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    #200000;
    n_fail++;
    test_done();
  end

  initial begin
    do_reset();
    $display("test reset done");
    foreach (rows[i]) run(rows[i]);
    $display("test table done");
    wb(1'b1, REG_BANK_SELECT, 32'h0000_00ab);
    #1;
    `CHK("wb_bank", 4'hb, bank_select_o)
    wb(1'b0, REG_BANK_SELECT, 32'h0);
    `CHK("wb_bank_rd", 32'h0000_000b, q)
    wb(1'b0, 8'hfc, 32'h0);
    `CHK("wb_unmapped", 32'h0, q)
    $display("test bus done");
    wb(1'b1, REG_CONTROL, 32'h1);
    wb(1'b0, REG_CONTROL, 32'h0);
    `CHK("wb_ctrl", 32'h0000_0001, q)
    run('{OP_BANKED, 0, 0, 8'h10, 12'h0, 12'h0, 8'h00, 8'h00, 12'h000, 4'hb, 2'd1});
    `CHK("unsup", 1'b1, unsupported_o)
    wb(1'b0, REG_STATUS, 32'h0);
    `CHK("wb_status", 32'h0001_0010, q)
    wb(1'b1, REG_CONTROL, 32'h0);
    $display("test extended done");
    do_reset();
    run('{OP_FULL_MOVE, 0, 0, 8'h00, 12'h110, 12'h040, 8'h00, 8'h5a, 12'h110, 4'h0, 2'd3});
    `CHK("unsup_clr", 1'b0, unsupported_o)
    $display("test retention done");
    test_done();
  end
endmodule // tb_top
